// file: hdl/pecd_pkg.sv
// Package for the port B / port C pin edge change detector.
// Assumes an APB slave with 32-bit data; each register one aligned word.
package pecd_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] OFS_B_RISE = 8'h00; // port_b_rise_enable
    localparam logic [7:0] OFS_B_FALL = 8'h04; // port_b_fall_enable
    localparam logic [7:0] OFS_B_FLAG = 8'h08; // port_b_change_flags
    localparam logic [7:0] OFS_C_RISE = 8'h0c; // port_c_rise_enable
    localparam logic [7:0] OFS_C_FALL = 8'h10; // port_c_fall_enable
    localparam logic [7:0] OFS_C_FLAG = 8'h14; // port_c_change_flags
    localparam logic [7:0] OFS_CTRL = 8'h18; // change_irq_enable in bit 0
    localparam logic [7:0] OFS_STAT = 8'h1c; // Summary flag in bit 0

    // Implemented bits of each port
    localparam logic [7:0] B_MASK = 8'hf0; // Port B uses bits 7-4
    localparam logic [7:0] C_MASK_SMALL = 8'h3f; // Smaller variant
    localparam logic [7:0] C_MASK_LARGE = 8'hff; // Larger variant

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00; // All enables and flags
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000; // Unmapped read

    // Bit positions of the one-bit control and status fields
    localparam int IRQ_EN_BIT = 0; // change_irq_enable
    localparam int SUMMARY_BIT = 0; // change_summary_flag

    // Enables and flags of one port travel together
    typedef struct packed {
        logic [7:0] rise; // Rising-edge enables
        logic [7:0] fall; // Falling-edge enables
        logic [7:0] flag; // Change flags
    } pecd_port_s;

endpackage : pecd_pkg

// file: hdl/pecd_sync.sv
// Two-flop synchroniser plus previous-sample stage for one pin group.
// Assumes pins may change at any time relative to pclk.
`timescale 1ns/10ps
module pecd_sync #(
    parameter int W = 8 // Pins in the group
) (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, low active
    input wire logic [W-1:0] pin, // Raw pins
    output logic [W-1:0] rise, // Rising edge seen, one-cycle pulse
    output logic [W-1:0] fall // Falling edge seen, one-cycle pulse
);
    logic [W-1:0] meta_r; // First stage; only sync_r reads it
    logic [W-1:0] sync_r; // Synchronised sample
    logic [W-1:0] prev_r; // Previous synchronised sample

    // Register the chain; reset to low so a pin held low gives no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Compare the current sample with the one before
    always_comb begin
        rise = sync_r & ~prev_r;
        fall = ~sync_r & prev_r;
    end
endmodule : pecd_sync

// file: hdl/pecd_port.sv
// Enable and flag logic for one port, with its own edge detectors.
// Assumes writes arrive as one-cycle strobes with the new byte.
`timescale 1ns/10ps
module pecd_port
    import pecd_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hff // Implemented bit positions
) (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, low active
    input wire logic [7:0] pin, // Port pins
    input wire logic wr_rise, // Write strobe, rise enables
    input wire logic wr_fall, // Write strobe, fall enables
    input wire logic wr_flag, // Write strobe, flags
    input wire logic [7:0] wdata, // Written byte
    output pecd_port_s regs // Current register contents
);
    pecd_port_s st_r; // Register state
    pecd_port_s st_nxt; // Next value
    logic [7:0] rise_ev; // Rising edges seen
    logic [7:0] fall_ev; // Falling edges seen
    logic [7:0] hit; // Enabled edges this cycle

    pecd_sync #(.W(8)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(pin),
        .rise(rise_ev),
        .fall(fall_ev)
    );

    // Next-state: an enabled edge always beats a software write
    always_comb begin
        // Disabled directions never count
        hit = ((rise_ev & st_r.rise) | (fall_ev & st_r.fall)) & MASK;
        st_nxt = st_r;
        if (wr_rise) begin
            st_nxt.rise = wdata & MASK;
        end
        if (wr_fall) begin
            st_nxt.fall = wdata & MASK;
        end
        if (wr_flag) begin
            st_nxt.flag = wdata & MASK;
        end
        // Set wins over the write in the same cycle
        st_nxt.flag = st_nxt.flag | hit;
    end

    // Registers; all enables and flags clear on any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.rise <= REG_RESET;
            st_r.fall <= REG_RESET;
            st_r.flag <= REG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regs = st_r;
endmodule : pecd_port

// file: hdl/pecd_top.sv
// Pin edge change detector, ports B and C, with APB register access.
// Assumes pins are synchronised inside; APB master follows the standard.
`timescale 1ns/10ps
module pecd_top
    import pecd_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1 // Port B and port C bits 7-6 exist
) (
    input wire logic pclk, // Core clock, 200 MHz
    input wire logic presetn, // Async reset, low active
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [7:0] port_b_pin, // Port B pins (7-4 used in the large variant, none in the smaller)
    input wire logic [7:0] port_c_pin, // Port C pins
    output logic change_summary_flag, // OR of all flags
    output logic irq, // Interrupt request, level
    output logic wake // Wake request from sleep, level
);
    localparam logic [7:0] BMASK = LARGE_VARIANT ? B_MASK : 8'h00;
    localparam logic [7:0] CMASK = LARGE_VARIANT ? C_MASK_LARGE : C_MASK_SMALL;

    pecd_port_s b_regs; // Port B register contents
    pecd_port_s c_regs; // Port C register contents
    logic irq_en_r; // change_irq_enable
    logic irq_en_nxt; // Next change_irq_enable
    logic [31:0] rdata_r; // Registered read data
    logic [31:0] rdata_nxt; // Next read data
    logic err_r; // Registered error
    logic err_nxt; // Next error
    logic setup; // APB setup phase
    logic wr_en; // Write in access phase, committed at access edge
    logic lane0; // Byte lane 0 is written
    logic hit_map; // Address is mapped
    logic [7:0] wbyte; // Low write byte

    // The access phase is a single cycle: read data are latched in setup
    assign setup = psel & ~penable;
    assign lane0 = pstrb[0];
    assign wbyte = pwdata[7:0];
    // Writes land at the access edge, when pready is sampled high
    assign wr_en = psel & penable & pwrite & lane0 & hit_map;

    // Address decode
    always_comb begin
        unique case (paddr)
            OFS_B_RISE, OFS_B_FALL, OFS_B_FLAG,
            OFS_C_RISE, OFS_C_FALL, OFS_C_FLAG,
            OFS_CTRL, OFS_STAT: hit_map = 1'b1;
            default: hit_map = 1'b0;
        endcase
    end

    pecd_port #(.MASK(BMASK)) u_port_b (
        .pclk(pclk),
        .presetn(presetn),
        .pin(port_b_pin),
        .wr_rise(wr_en && paddr == OFS_B_RISE),
        .wr_fall(wr_en && paddr == OFS_B_FALL),
        .wr_flag(wr_en && paddr == OFS_B_FLAG),
        .wdata(wbyte),
        .regs(b_regs)
    );

    pecd_port #(.MASK(CMASK)) u_port_c (
        .pclk(pclk),
        .presetn(presetn),
        .pin(port_c_pin),
        .wr_rise(wr_en && paddr == OFS_C_RISE),
        .wr_fall(wr_en && paddr == OFS_C_FALL),
        .wr_flag(wr_en && paddr == OFS_C_FLAG),
        .wdata(wbyte),
        .regs(c_regs)
    );

    // Next values of control and read data
    always_comb begin
        irq_en_nxt = irq_en_r;
        if (wr_en && paddr == OFS_CTRL) begin
            irq_en_nxt = wbyte[IRQ_EN_BIT];
        end
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        if (setup) begin
            // Capture in setup so the access phase answers at once
            err_nxt = ~hit_map;
            rdata_nxt = RDATA_ZERO;
            unique case (paddr)
                OFS_B_RISE: rdata_nxt[7:0] = b_regs.rise;
                OFS_B_FALL: rdata_nxt[7:0] = b_regs.fall;
                OFS_B_FLAG: rdata_nxt[7:0] = b_regs.flag;
                OFS_C_RISE: rdata_nxt[7:0] = c_regs.rise;
                OFS_C_FALL: rdata_nxt[7:0] = c_regs.fall;
                OFS_C_FLAG: rdata_nxt[7:0] = c_regs.flag;
                OFS_CTRL: rdata_nxt[IRQ_EN_BIT] = irq_en_r;
                OFS_STAT: rdata_nxt[SUMMARY_BIT] = change_summary_flag;
                default: rdata_nxt = RDATA_ZERO;
            endcase
        end
    end

    // Register control and bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= 1'b0;
            rdata_r <= RDATA_ZERO;
            err_r <= 1'b0;
        end else begin
            irq_en_r <= irq_en_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end

    // Zero-wait slave; error only on an unmapped address
    always_comb begin
        pready = 1'b1;
        pslverr = psel & penable & err_r;
        prdata = (psel & penable & ~pwrite) ? rdata_r : RDATA_ZERO;
    end

    // Summary is the OR of all flags, independent of the enable
    assign change_summary_flag = |{b_regs.flag, c_regs.flag};
    // Only forwarding is gated by the enable
    assign irq = change_summary_flag & irq_en_r;
    // Wake is irq itself, so it rises in the same cycle as the registered flag
    assign wake = irq;
endmodule : pecd_top

// file: verif/pecd_pins.sv
// Pin drive model: turns bench requests into port pin levels.
// Assumes the bench holds the pins low across every reset.
`timescale 1ns/10ps
module pecd_pins (
    input wire logic pclk, // Core clock
    input wire logic [7:0] b_req, // Wanted port B levels
    input wire logic [7:0] c_req, // Wanted port C levels
    output logic [7:0] port_b_pin = 8'h00, // Port B pins
    output logic [7:0] port_c_pin = 8'h00 // Port C pins
);
    // One cycle of skew; pins move on a pclk edge, as the APB signals do
    always_ff @(posedge pclk) begin
        port_b_pin <= b_req;
        port_c_pin <= c_req;
    end
endmodule : pecd_pins

// file: verif/pecd_top_asserts.sv
// Port-level checker for the pin edge change detector.
// Assumes pins stay low while presetn is low, so no edge hides in reset.
`timescale 1ns/10ps
module pecd_top_asserts
    import pecd_pkg::*;
(
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, low active
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic [7:0] port_b_pin, // Port B pins
    input wire logic [7:0] port_c_pin, // Port C pins
    input wire logic change_summary_flag, // Summary flag
    input wire logic irq, // Interrupt request
    input wire logic wake // Wake request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable; // Access phase
    wire logic rd = acc && !pwrite; // Read access
    AST_READY: assert property (pready)
        else $error("pready low");
    AST_UPPER: assert property (rd |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_B_LOW: assert property (rd && paddr <= OFS_B_FLAG |->
        prdata[3:0] == 4'h0) else $error("port B low bits set");
    AST_UNMAPPED: assert property (acc && paddr[1:0] == 2'b00 |->
        pslverr == (paddr > OFS_STAT)) else $error("pslverr wrong");
    AST_STATUS: assert property (rd && paddr == OFS_STAT |->
        prdata == {31'h0, $past(change_summary_flag)})
        else $error("status differs from summary");
    AST_IRQ: assert property (irq |-> change_summary_flag)
        else $error("irq without flag");
    AST_WAKE: assert property (wake == irq)
        else $error("wake differs from irq");
    // A flag only appears three cycles after a pin move, or by a write
    AST_RISE: assert property ($rose(change_summary_flag) |->
        $past(port_b_pin, 3) != $past(port_b_pin, 4) ||
        $past(port_c_pin, 3) != $past(port_c_pin, 4) ||
        $past(acc && pwrite)) else $error("flag with no cause");
    AST_HOLD: assert property ($fell(change_summary_flag) |->
        $past(acc && pwrite)) else $error("flag dropped by itself");
    COV_WR: cover property (acc && pwrite);
    COV_SUM: cover property (rd && paddr == OFS_STAT && prdata[0]);
    COV_IRQ: cover property ($rose(irq));
endmodule : pecd_top_asserts
bind pecd_top pecd_top_asserts CHK (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .port_b_pin, .port_c_pin,
    .change_summary_flag, .irq, .wake);

// file: verif/pecd_top_tb_top.sv
// Self-checking bench: APB master, pin model and a register model.
// Assumes the pin model adds one cycle between request and pins.
`timescale 1ns/10ps
module pecd_top_tb_top import pecd_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0; // Clock and reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
    logic [7:0] paddr = 8'h00, b_req = 8'h00, c_req = 8'h00, pb, pc;
    logic [31:0] pwdata = 32'h0, prdata, rdv, lfsr = 32'he9fb;
    logic [3:0] pstrb = 4'hf; // Byte strobes
    logic pready, pslverr, csf, irq, wake, errv;
    logic [7:0] m [8]; // Model registers by word index
    int err_count = 0, num_checks = 0;
    initial forever #2.5 pclk = ~pclk;
    pecd_top #(.LARGE_VARIANT(1'b1)) DUT (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .port_b_pin(pb), .port_c_pin(pc),
        .change_summary_flag(csf), .irq, .wake);
    pecd_pins PINS (.pclk, .b_req, .c_req, .port_b_pin(pb), .port_c_pin(pc));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    // Implemented bits of each word; status is computed, never stored
    function automatic logic [7:0] msk(input int i);
        return i < 3 ? B_MASK : (i < 6 ? C_MASK_LARGE : 8'h01);
    endfunction : msk
    function automatic logic sm();
        return |{m[2], m[5]};
    endfunction : sm
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n++ < 50) @(posedge pclk);
        // A slave that never answers ends the run as a failure
        if (pready !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        rdv = prdata;
        errv = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, 8'(i * 4), d);
        if (i < 7 && pstrb[0]) m[i] = d[7:0] & msk(i);
    endtask : wr
    task automatic rd(input int i);
        apb(1'b0, 8'(i * 4), 32'h0);
        check(rdv, {24'h0, i == 7 ? {7'h0, sm()} : m[i]});
    endtask : rd
    // Model takes enabled edges from the old levels, then pins move
    task automatic pins(input logic [7:0] b, input logic [7:0] c);
        m[2] |= ((b & ~b_req & m[0]) | (~b & b_req & m[1])) & B_MASK;
        m[5] |= (c & ~c_req & m[3]) | (~c & c_req & m[4]);
        @(posedge pclk);
        {b_req, c_req} <= {b, c};
        repeat (6) @(posedge pclk);
        check({irq, csf}, {m[6][0] & sm(), sm()});
    endtask : pins
    task automatic rst();
        int i;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++) m[i] = 8'h00;
        for (i = 0; i < 8; i++) rd(i);
    endtask : rst
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        int i, k;
        rst();
        $display("reset values done");
        // Random writes read back through the implemented-bit masks
        for (k = 0; k < 24; k++) begin
            lfsr = nxt(lfsr);
            wr(k % 8, lfsr);
            rd(k % 8);
        end
        pstrb <= 4'h0;
        wr(0, 32'hff); // Dropped: strobe bit 0 low
        pstrb <= 4'hf;
        rd(0);
        apb(1'b1, 8'h20, 32'hff);
        check({31'h0, errv}, 32'h1);
        $display("register access done");
        // Random enables and pin moves; irq mask toggles each pass
        for (k = 0; k < 16; k++) begin
            lfsr = nxt(lfsr);
            for (i = 0; i < 4; i++) wr(i < 2 ? i : i + 1, lfsr >> (8 * i));
            wr(2, 32'h0);
            wr(5, 32'h0);
            wr(6, k);
            lfsr = nxt(lfsr);
            pins(lfsr[7:0], lfsr[15:8]);
            for (i = 2; i < 8; i += 3) rd(i);
        end
        $display("edge detection done");
        pins(8'h00, 8'h00);
        // Port C bit 0 rises so its edge lands on the clearing write's
        // access edge: bit 7 clears, bit 0 must stay set
        wr(3, 32'h01);
        wr(5, 32'h80);
        @(posedge pclk);
        c_req <= 8'h01;
        @(posedge pclk);
        wr(5, 32'h00);
        m[5] = 8'h01;
        rd(5);
        $display("clear race done");
        pins(8'h00, 8'h00);
        rst();
        $display("second reset done");
        print_verdict();
    end
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
endmodule : pecd_top_tb_top
